// File: rtl/xfer_pkg.sv
// Constants for the accumulator-to-control-register transfer block.
// Assumes a 4-bit core with a 10-bit instruction word and one clock.
package xfer_pkg;
	localparam int DATA_W  = 4;
	localparam int INSTR_W = 10;
	localparam int PRE_W   = 8;

	localparam logic [9:0] CODE_LOAD_CLOCK_MODE = 10'h216;
	localparam logic [9:0] CODE_LOAD_TIMER_CTRL = 10'h2AA;
	localparam logic [9:0] CODE_LOAD_PRESCALE   = 10'h235;
	localparam logic [9:0] CODE_LOAD_PULLUP_0   = 10'h22D;

	localparam int TIMER_BIT_POS = 0;
	localparam int LOW_NIB_LSB   = 0;
	localparam int HIGH_NIB_LSB  = 4;

	localparam logic [3:0] CLOCK_MODE_RESET = 4'h0;
	localparam logic       TIMER_CTRL_RESET = 1'b0;
	localparam logic [7:0] PRESCALE_RESET   = 8'h00;
	localparam logic [3:0] PULLUP_0_RESET   = 4'h0;

	typedef enum logic [4:0] {
		OP_NONE             = 5'b00001,
		OP_LOAD_CLOCK_MODE  = 5'b00010,
		op_load_timer_ctrl  = 5'b00100,
		OP_LOAD_PRESCALE    = 5'b01000,
		op_load_pullup_0    = 5'b10000
	} op_type;
endpackage

// File: rtl/decode_if.sv
// Decoded operation carried from the decoder to the execution logic.
// Assumes both ends sit on clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface decode_if;
	logic [9:0]      instr;
	logic            exec;
	xfer_pkg::op_type op;

	modport decoder (input instr, input exec, output op);
	modport user    (output instr, output exec, input op);
endinterface
`default_nettype wire

// File: rtl/xfer_decoder.sv
// Combinational decoder of the four transfer instruction codes.
// Assumes instr is stable while exec is high.
`timescale 1ns/100ps
`default_nettype none
module xfer_decoder (
	decode_if.decoder dec
);
	always_comb begin
		if (!dec.exec) begin
			dec.op = xfer_pkg::OP_NONE;
		end else begin
			case (dec.instr)
				xfer_pkg::CODE_LOAD_CLOCK_MODE: begin
					dec.op = xfer_pkg::OP_LOAD_CLOCK_MODE;
				end
				xfer_pkg::CODE_LOAD_TIMER_CTRL: begin
					dec.op = xfer_pkg::op_load_timer_ctrl;
				end
				xfer_pkg::CODE_LOAD_PRESCALE: begin
					dec.op = xfer_pkg::OP_LOAD_PRESCALE;
				end
				xfer_pkg::CODE_LOAD_PULLUP_0: begin
					dec.op = xfer_pkg::op_load_pullup_0;
				end
				default: begin
					dec.op = xfer_pkg::OP_NONE;
				end
			endcase
		end
	end
endmodule // xfer_decoder
`default_nettype wire

// File: rtl/accum_to_control_reg_transfer.sv
// Execution of the accumulator-to-control-register transfers.
// Assumes instr, exec, acc and breg come from core logic on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module accum_to_control_reg_transfer (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [9:0]  instr,
	input  wire logic        exec,
	input  wire logic [3:0]  acc,
	input  wire logic [3:0]  breg,
	input  wire logic        prescale_tick,
	output logic [3:0]       clock_mode_reg,
	output logic             timer_ctrl_bit,
	output logic [7:0]       prescale_count,
	output logic [7:0]       prescale_reload,
	output logic [3:0]       pullup_ctrl_0,
	output logic             prescale_wrap,
	output logic             acc_write,
	output logic             breg_write,
	output logic             carry_write,
	output logic             skip_next
);
	decode_if dec ();
	xfer_pkg::op_type op;

	// True when an executing cycle carries the given instruction code
	function automatic logic takes(
		input logic       ex,
		input logic [9:0] word,
		input logic [9:0] code
	);
		return ex && (word == code);
	endfunction

	assign dec.instr = instr;
	assign dec.exec  = exec;
	assign op        = dec.op;

	xfer_decoder u_decoder (
		.dec (dec)
	);

	// Transfers never write core state nor request a skip
	assign acc_write   = 1'b0;
	assign breg_write  = 1'b0;
	assign carry_write = 1'b0;
	assign skip_next   = 1'b0;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clock_mode_reg <= xfer_pkg::CLOCK_MODE_RESET;
		end else if (op == xfer_pkg::OP_LOAD_CLOCK_MODE) begin
			clock_mode_reg <= acc;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_ctrl_bit <= xfer_pkg::TIMER_CTRL_RESET;
		end else if (op == xfer_pkg::op_load_timer_ctrl) begin
			timer_ctrl_bit <= acc[xfer_pkg::TIMER_BIT_POS];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prescale_reload <= xfer_pkg::PRESCALE_RESET;
		end else if (op == xfer_pkg::OP_LOAD_PRESCALE) begin
			prescale_reload <= {breg, acc};
		end
	end

	// A load wins over a count tick in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prescale_count <= xfer_pkg::PRESCALE_RESET;
			prescale_wrap  <= 1'b0;
		end else if (op == xfer_pkg::OP_LOAD_PRESCALE) begin
			prescale_count <= {breg, acc};
			prescale_wrap  <= 1'b0;
		end else if (prescale_tick) begin
			if (prescale_count == 8'h00) begin
				prescale_count <= prescale_reload;
				prescale_wrap  <= 1'b1;
			end else begin
				prescale_count <= prescale_count - 8'h01;
				prescale_wrap  <= 1'b0;
			end
		end else begin
			prescale_wrap <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pullup_ctrl_0 <= xfer_pkg::PULLUP_0_RESET;
		end else if (op == xfer_pkg::op_load_pullup_0) begin
			pullup_ctrl_0 <= acc;
		end
	end

	// Every property below runs on the core clock and pauses in reset
	default clocking main_cb @(posedge clk_sys);
	endclocking

	default disable iff (!rst_n);

	clock_mode_load_a: assert property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_CLOCK_MODE)
			|=> clock_mode_reg == $past(acc))
		else $error("clock mode register missed accumulator");

	clock_mode_hold_a: assert property (
		!takes(exec, instr, xfer_pkg::CODE_LOAD_CLOCK_MODE)
			|=> $stable(clock_mode_reg))
		else $error("clock mode register changed without its load");

	timer_bit_load_a: assert property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_TIMER_CTRL)
			|=> timer_ctrl_bit == $past(acc[xfer_pkg::TIMER_BIT_POS]))
		else $error("timer control bit not taken from bit 0");

	timer_bit_hold_a: assert property (
		!takes(exec, instr, xfer_pkg::CODE_LOAD_TIMER_CTRL)
			|=> $stable(timer_ctrl_bit))
		else $error("timer control bit changed without its load");

	prescale_high_a: assert property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_PRESCALE)
			|=> prescale_count[xfer_pkg::HIGH_NIB_LSB +: 4] == $past(breg)
			&& prescale_reload[xfer_pkg::HIGH_NIB_LSB +: 4] == $past(breg))
		else $error("prescaler upper nibble not from B");

	prescale_low_a: assert property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_PRESCALE)
			|=> prescale_count[xfer_pkg::LOW_NIB_LSB +: 4] == $past(acc)
			&& prescale_reload[xfer_pkg::LOW_NIB_LSB +: 4] == $past(acc))
		else $error("prescaler lower nibble not from accumulator");

	pullup_load_a: assert property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_PULLUP_0)
			|=> pullup_ctrl_0 == $past(acc))
		else $error("pull-up register missed accumulator");

	pullup_hold_a: assert property (
		!takes(exec, instr, xfer_pkg::CODE_LOAD_PULLUP_0)
			|=> $stable(pullup_ctrl_0))
		else $error("pull-up register changed without its load");

	reload_hold_a: assert property (
		!takes(exec, instr, xfer_pkg::CODE_LOAD_PRESCALE)
			|=> $stable(prescale_reload))
		else $error("reload register changed without a prescaler load");

	count_step_a: assert property (
		prescale_tick && prescale_count != 8'h00
			&& !takes(exec, instr, xfer_pkg::CODE_LOAD_PRESCALE)
			|=> prescale_count == $past(prescale_count) - 8'h01)
		else $error("prescaler count did not step down on a tick");

	count_wrap_a: assert property (
		prescale_tick && prescale_count == 8'h00
			&& !takes(exec, instr, xfer_pkg::CODE_LOAD_PRESCALE)
			|=> prescale_count == $past(prescale_reload) && prescale_wrap)
		else $error("prescaler did not reload and flag a wrap at zero");

	count_idle_a: assert property (
		!prescale_tick && !takes(exec, instr, xfer_pkg::CODE_LOAD_PRESCALE)
			|=> $stable(prescale_count) && !prescale_wrap)
		else $error("prescaler count moved without a tick or load");

	load_beats_tick_a: assert property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_PRESCALE) && prescale_tick
			|=> !prescale_wrap && prescale_count == {$past(breg), $past(acc)})
		else $error("a tick disturbed a prescaler load");

	wrap_cause_a: assert property (
		prescale_wrap |-> $past(prescale_tick)
			&& $past(prescale_count) == 8'h00)
		else $error("wrap flagged without a tick at zero");

	core_untouched_a: assert property (
		exec |-> !acc_write && !breg_write && !carry_write && !skip_next)
		else $error("transfer touched core state or skipped");

	decode_map_a: assert property (
		(takes(exec, instr, xfer_pkg::CODE_LOAD_CLOCK_MODE)
			== (op == xfer_pkg::OP_LOAD_CLOCK_MODE))
		&& (takes(exec, instr, xfer_pkg::CODE_LOAD_TIMER_CTRL)
			== (op == xfer_pkg::op_load_timer_ctrl))
		&& (takes(exec, instr, xfer_pkg::CODE_LOAD_PRESCALE)
			== (op == xfer_pkg::OP_LOAD_PRESCALE))
		&& (takes(exec, instr, xfer_pkg::CODE_LOAD_PULLUP_0)
			== (op == xfer_pkg::op_load_pullup_0)))
		else $error("decoded operation does not match the instruction code");

	decode_idle_a: assert property (
		!exec |-> op == xfer_pkg::OP_NONE)
		else $error("operation decoded without an executing instruction");

	decode_onehot_a: assert property (
		$onehot(op))
		else $error("decoded operation is not one-hot");

	reset_state_a: assert property (
		$rose(rst_n) |-> clock_mode_reg == xfer_pkg::CLOCK_MODE_RESET
			&& timer_ctrl_bit == xfer_pkg::TIMER_CTRL_RESET
			&& prescale_count == xfer_pkg::PRESCALE_RESET
			&& prescale_reload == xfer_pkg::PRESCALE_RESET
			&& pullup_ctrl_0 == xfer_pkg::PULLUP_0_RESET && !prescale_wrap)
		else $error("register not at its reset value after reset");

	// Scenarios worth seeing in a run
	clock_mode_seen_c: cover property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_CLOCK_MODE));
	timer_seen_c: cover property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_TIMER_CTRL));
	prescale_seen_c: cover property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_PRESCALE) ##1 prescale_tick[*3]);
	pullup_seen_c: cover property (
		takes(exec, instr, xfer_pkg::CODE_LOAD_PULLUP_0));
	wrap_seen_c: cover property (
		prescale_wrap);
endmodule // accum_to_control_reg_transfer
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the accumulator-to-control-register transfers.
// Assumes the transfer block and its package are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	typedef struct {
		logic [9:0] ins;
		logic       ex;
		logic       tk;
		logic [3:0] a;
		logic [3:0] b;
	} row_type;

	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	logic [9:0] instr = 10'h000;
	logic       exec = 1'b0;
	logic [3:0] acc = 4'h0;
	logic [3:0] breg = 4'h0;
	logic       prescale_tick = 1'b0;
	logic [3:0] clock_mode_reg;
	logic       timer_ctrl_bit;
	logic [7:0] prescale_count;
	logic [7:0] prescale_reload;
	logic [3:0] pullup_ctrl_0;
	logic       prescale_wrap;
	logic       acc_write;
	logic       breg_write;
	logic       carry_write;
	logic       skip_next;
	logic [3:0] e_cm, e_pu;
	logic [7:0] e_pc, e_pr;
	logic       e_tc, e_wr;
	int         error_cnt = 0;
	int         n_checks = 0;
	row_type    rows [14];

	always #50 clk_sys = ~clk_sys;

	accum_to_control_reg_transfer accum_to_control_reg_transfer_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .instr(instr), .exec(exec),
		.acc(acc), .breg(breg), .prescale_tick(prescale_tick),
		.clock_mode_reg(clock_mode_reg), .timer_ctrl_bit(timer_ctrl_bit),
		.prescale_count(prescale_count), .prescale_reload(prescale_reload),
		.pullup_ctrl_0(pullup_ctrl_0), .prescale_wrap(prescale_wrap),
		.acc_write(acc_write), .breg_write(breg_write),
		.carry_write(carry_write), .skip_next(skip_next)
	);

	task automatic end_sim;
		$display("checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic clr;
		{e_cm, e_tc, e_pc, e_pr, e_pu, e_wr} = '0;
	endtask

	task automatic chk;
		n_checks++;
		if ({clock_mode_reg, timer_ctrl_bit, prescale_count, prescale_reload,
		     pullup_ctrl_0, prescale_wrap}
		    !== {e_cm, e_tc, e_pc, e_pr, e_pu, e_wr}) begin
			error_cnt++;
			$display("mismatch at %0t: register state", $time);
		end
		n_checks++;
		if ({acc_write, breg_write, carry_write, skip_next} !== 4'h0) begin
			error_cnt++;
			$display("mismatch at %0t: core write or skip raised", $time);
		end
	endtask

	// Reference update for one executed cycle; a load beats a tick
	task automatic apply(input row_type r);
		e_wr = 1'b0;
		if (r.ex && r.ins === xfer_pkg::CODE_LOAD_PRESCALE) begin
			e_pc = {r.b, r.a};
			e_pr = {r.b, r.a};
		end else if (r.tk) begin
			if (e_pc === 8'h00) begin
				e_pc = e_pr;
				e_wr = 1'b1;
			end else e_pc = e_pc - 8'h01;
		end
		if (r.ex) begin
			case (r.ins)
				xfer_pkg::CODE_LOAD_CLOCK_MODE: e_cm = r.a;
				xfer_pkg::CODE_LOAD_TIMER_CTRL: e_tc = r.a[0];
				xfer_pkg::CODE_LOAD_PULLUP_0:   e_pu = r.a;
				default: ;
			endcase
		end
	endtask

	initial begin
		#20000;
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end

	initial begin
		rows = '{
			'{10'h216, 1'b1, 1'b0, 4'h5, 4'h0},
			'{10'h2AA, 1'b1, 1'b0, 4'h3, 4'h0},
			'{10'h2AA, 1'b1, 1'b0, 4'hE, 4'h0},
			'{10'h2AA, 1'b1, 1'b0, 4'hF, 4'h0},
			'{10'h235, 1'b1, 1'b0, 4'h6, 4'hA},
			'{10'h22D, 1'b1, 1'b0, 4'h9, 4'h0},
			'{10'h3FF, 1'b1, 1'b0, 4'hF, 4'hF},
			'{10'h216, 1'b0, 1'b0, 4'hC, 4'h0},
			'{10'h235, 1'b1, 1'b0, 4'h1, 4'h0},
			'{10'h000, 1'b0, 1'b1, 4'h0, 4'h0},
			'{10'h000, 1'b0, 1'b1, 4'h0, 4'h0},
			'{10'h235, 1'b1, 1'b1, 4'h6, 4'hA},
			'{10'h22D, 1'b1, 1'b0, 4'h0, 4'h0},
			'{10'h216, 1'b1, 1'b0, 4'hF, 4'hF}
		};
		clr();
		repeat (3) @(posedge clk_sys);
		chk();
		rst_n <= 1'b1;
		// Back-to-back rows: each edge samples the previous row
		for (int i = 0; i <= 14; i++) begin
			@(posedge clk_sys);
			if (i < 14) begin
				{instr, exec, prescale_tick, acc, breg} <= {rows[i].ins,
					rows[i].ex, rows[i].tk, rows[i].a, rows[i].b};
			end else {exec, prescale_tick} <= 2'b00;
			@(negedge clk_sys);
			chk();
			if (i < 14) apply(rows[i]);
		end
		// Reset in mid-run clears every register
		@(posedge clk_sys);
		rst_n <= 1'b0;
		@(negedge clk_sys);
		clr();
		chk();
		@(posedge clk_sys);
		rst_n <= 1'b1;
		{instr, exec} <= {xfer_pkg::CODE_LOAD_PRESCALE, 1'b1};
		{acc, breg} <= {4'h3, 4'hC};
		@(posedge clk_sys);
		exec <= 1'b0;
		prescale_tick <= 1'b1;
		@(negedge clk_sys);
		e_pc = 8'hC3;
		e_pr = 8'hC3;
		chk();
		// Three ticks straight after the load step the count down
		repeat (3) @(posedge clk_sys);
		prescale_tick <= 1'b0;
		@(negedge clk_sys);
		e_pc = 8'hC0;
		chk();
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
